// *** pfc_port_flow_ctrl.sv ***
module pfc_port_flow_ctrl #(
    parameter int ADDR_W = 12
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              sys_rst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Configuration straps
    input  wire logic              backpressure_strap,
    input  wire logic              full_duplex_pause_strap,
    input  wire logic              manual_select_strap,
    input  wire logic              duplexStrap,
    // Loader rewrite of the straps
    input  wire logic              loaderWrite,
    input  wire logic              loaderBackpressure,
    input  wire logic              loaderPause,
    input  wire logic              loaderManual,
    input  wire logic              loaderDuplex,
    // Port link state
    input  wire logic              linkHalfDuplex,
    input  wire logic              anEnabled,
    input  wire logic              anPauseRx,
    input  wire logic              anPauseTx,
    // Flow control in force
    output logic                   backpressureActive,
    output logic                   pauseRxActive,
    output logic                   pauseTxActive
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        pfc_pkg::pfc_bus_e bus;
        logic [31:0]       rdata;
        logic              ready;
        logic              err;
        logic              backpressureGate;
        logic              pauseRxGate;
        logic              pauseTxGate;
        logic              manualSel;
        logic              bpActive;
    } pfc_top_s;

    pfc_top_s q, d;

    logic strapBp;
    logic strapPause;
    logic strapMan;
    logic strapDup;
    logic loadPulse;
    logic curRx;
    logic curTx;
    logic curDup;
    logic hit;
    logic resMan;
    logic resRx;
    logic resTx;
    logic resDup;
    logic [31:0] readWord;

    // ****************************************
    // Strap capture and loader rewrite
    // ****************************************
    pfc_strap_latch u_straps (
        .ref_clk                 (ref_clk),
        .sys_rst                 (sys_rst),
        .backpressure_strap      (backpressure_strap),
        .full_duplex_pause_strap (full_duplex_pause_strap),
        .manual_select_strap     (manual_select_strap),
        .duplexStrap             (duplexStrap),
        .loaderWrite             (loaderWrite),
        .loaderBackpressure      (loaderBackpressure),
        .loaderPause             (loaderPause),
        .loaderManual            (loaderManual),
        .loaderDuplex            (loaderDuplex),
        .strapBackpressure       (strapBp),
        .strapPause              (strapPause),
        .strapManual             (strapMan),
        .strapDuplex             (strapDup),
        .loadPulse               (loadPulse)
    );

    // ****************************************
    // Resolution of the settings in force
    // ****************************************
    // status from straps
    // On a strap load the status is built from the fresh strap values
    always_comb begin
        resMan = loadPulse ? strapMan : q.manualSel;
        resRx  = loadPulse ? strapPause : q.pauseRxGate;
        resTx  = loadPulse ? strapPause : q.pauseTxGate;
        resDup = loadPulse ? strapDup : linkHalfDuplex;
    end

    pfc_pause_resolve u_resolve (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .manualSel  (resMan),
        .anEnabled  (anEnabled),
        .rxGate     (resRx),
        .txGate     (resTx),
        .anPauseRx  (anPauseRx),
        .anPauseTx  (anPauseTx),
        .halfDuplex (resDup),
        .pauseRxOn  (curRx),
        .pauseTxOn  (curTx),
        .duplexHalf (curDup)
    );

    // ****************************************
    // Read word
    // ****************************************
    // reserved read zero
    always_comb begin
        readWord = pfc_pkg::READ_ZERO;
        readWord[pfc_pkg::BIT_BACKPRESSURE] = q.backpressureGate;
        readWord[pfc_pkg::BIT_DUPLEX] = curDup;
        readWord[pfc_pkg::BIT_CUR_RX] = curRx;
        readWord[pfc_pkg::BIT_CUR_TX] = curTx;
        readWord[pfc_pkg::BIT_RX_GATE] = q.pauseRxGate;
        readWord[pfc_pkg::BIT_TX_GATE] = q.pauseTxGate;
        readWord[pfc_pkg::BIT_MANUAL] = q.manualSel;
    end

    assign hit = (paddr[ADDR_W-1:2] == pfc_pkg::REG_OFFSET[ADDR_W-1:2]);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        d = q;
        d.ready = 1'b0;
        d.err   = 1'b0;
        case (q.bus)
            pfc_pkg::ST_IDLE: begin
                if (psel && !penable) begin
                    d.bus = pfc_pkg::ST_ACCESS;
                end
            end
            pfc_pkg::ST_ACCESS: begin
                // Answer one cycle into the access phase
                if (psel && penable) begin
                    d.bus   = pfc_pkg::ST_RESP;
                    d.ready = 1'b1;
                    d.err   = !hit;
                    d.rdata = (hit && !pwrite) ? readWord : pfc_pkg::READ_ZERO;
                end else begin
                    d.bus = pfc_pkg::ST_IDLE;
                end
            end
            pfc_pkg::ST_RESP: begin
                d.rdata = pfc_pkg::READ_ZERO;
                d.bus   = (psel && !penable) ? pfc_pkg::ST_ACCESS : pfc_pkg::ST_IDLE;
            end
            default: begin
                d.bus = pfc_pkg::ST_IDLE;
            end
        endcase

        // local write only
        // Write lands at the edge where pready is seen high
        if (q.ready && psel && penable && pwrite && hit) begin
            d.backpressureGate = pwdata[pfc_pkg::BIT_BACKPRESSURE];
            d.pauseRxGate      = pwdata[pfc_pkg::BIT_RX_GATE];
            d.pauseTxGate      = pwdata[pfc_pkg::BIT_TX_GATE];
            d.manualSel        = pwdata[pfc_pkg::BIT_MANUAL];
        end

        // strap reload
        // A loader rewrite wins over a write in the same cycle
        if (loadPulse) begin
            d.backpressureGate = strapBp;
            d.pauseRxGate      = strapPause;
            d.pauseTxGate      = strapPause;
            d.manualSel        = strapMan;
        end

        d.bpActive = q.backpressureGate && linkHalfDuplex;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q.bus              <= pfc_pkg::ST_IDLE;
            q.rdata            <= pfc_pkg::READ_ZERO;
            q.ready            <= 1'b0;
            q.err              <= 1'b0;
            q.backpressureGate <= pfc_pkg::RST_GATE;
            q.pauseRxGate      <= pfc_pkg::RST_GATE;
            q.pauseTxGate      <= pfc_pkg::RST_GATE;
            q.manualSel        <= pfc_pkg::RST_GATE;
            q.bpActive         <= pfc_pkg::RST_STATUS;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign prdata             = q.rdata;
    assign pready             = q.ready;
    assign pslverr            = q.err;
    assign backpressureActive = q.bpActive;
    assign pauseRxActive      = curRx;
    assign pauseTxActive      = curTx;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_setup;
        psel && !penable;
    endsequence

    sequence s_access;
        psel && penable;
    endsequence

    sequence s_reg_write;
        pready && psel && penable && pwrite && hit && !loadPulse;
    endsequence

    sequence s_reg_read;
        pready && psel && penable && !pwrite && hit;
    endsequence

    property p_backpressure;
        ##1 backpressureActive == $past(q.backpressureGate && linkHalfDuplex);
    endproperty
    a_backpressure: assert property (p_backpressure)
        else $error("backpressure output does not follow gate and duplex");

    property p_duplex_read;
        s_reg_read |-> prdata[pfc_pkg::BIT_DUPLEX] == $past(curDup);
    endproperty
    a_duplex_read: assert property (p_duplex_read)
        else $error("duplex status bit wrong on read");

    property p_rx_read;
        s_reg_read |-> prdata[pfc_pkg::BIT_CUR_RX] == $past(pauseRxActive);
    endproperty
    a_rx_read: assert property (p_rx_read)
        else $error("receive pause status wrong on read");

    property p_tx_read;
        s_reg_read |-> prdata[pfc_pkg::BIT_CUR_TX] == $past(pauseTxActive);
    endproperty
    a_tx_read: assert property (p_tx_read)
        else $error("transmit pause status wrong on read");

    property p_write_lands;
        s_reg_write |=> q.pauseRxGate == $past(pwdata[pfc_pkg::BIT_RX_GATE])
            && q.pauseTxGate == $past(pwdata[pfc_pkg::BIT_TX_GATE])
            && q.manualSel == $past(pwdata[pfc_pkg::BIT_MANUAL]);
    endproperty
    a_write_lands: assert property (p_write_lands)
        else $error("written gate bits not stored");

    // Reset drops at the release edge, before the outputs leave reset values
    property p_manual_full;
        $past(!sys_rst && q.manualSel && !linkHalfDuplex && !loadPulse)
            |-> pauseTxActive == $past(q.pauseTxGate)
            && pauseRxActive == $past(q.pauseRxGate);
    endproperty
    a_manual_full: assert property (p_manual_full)
        else $error("manual select does not apply transmit gate");

    property p_auto_neg;
        $past(!sys_rst && !q.manualSel && anEnabled && !linkHalfDuplex && !loadPulse)
            |-> pauseRxActive == $past(anPauseRx) && pauseTxActive == $past(anPauseTx);
    endproperty
    a_auto_neg: assert property (p_auto_neg)
        else $error("negotiated pause result not applied");

    property p_no_neg;
        $past(!sys_rst && !q.manualSel && !anEnabled && !linkHalfDuplex && !loadPulse)
            |-> pauseRxActive == $past(q.pauseRxGate)
            && pauseTxActive == $past(q.pauseTxGate);
    endproperty
    a_no_neg: assert property (p_no_neg)
        else $error("written receive gate not applied without negotiation");

    property p_half_no_pause;
        $past(!sys_rst && linkHalfDuplex && !loadPulse) |-> !pauseRxActive && !pauseTxActive;
    endproperty
    a_half_no_pause: assert property (p_half_no_pause)
        else $error("pause in force during half duplex");

    property p_strap_load;
        loadPulse |=> q.backpressureGate == $past(strapBp)
            && q.manualSel == $past(strapMan) && q.pauseRxGate == $past(strapPause);
    endproperty
    a_strap_load: assert property (p_strap_load)
        else $error("strap values not loaded into gate bits");

    property p_strap_status;
        loadPulse |=> curDup == $past(strapDup);
    endproperty
    a_strap_status: assert property (p_strap_status)
        else $error("duplex status not taken from straps");

    property p_reserved;
        pready |-> prdata[31:7] == 25'h0;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bits read nonzero");

    property p_answer_time;
        s_setup ##1 s_access |=> pready;
    endproperty
    a_answer_time: assert property (p_answer_time)
        else $error("answer not given one cycle into access");

endmodule

// *** pfc_pkg.sv ***
package pfc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] REG_OFFSET = 12'h1a4;
    localparam logic [31:0] RW_MASK    = 32'h0000_0047;
    localparam logic [31:0] READ_ZERO  = 32'h0000_0000;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int BIT_BACKPRESSURE = 6;
    localparam int BIT_DUPLEX       = 5;
    localparam int BIT_CUR_RX       = 4;
    localparam int BIT_CUR_TX       = 3;
    localparam int BIT_RX_GATE      = 2;
    localparam int BIT_TX_GATE      = 1;
    localparam int BIT_MANUAL       = 0;

    // ****************************************
    // Reset values before the straps are taken
    // ****************************************
    localparam logic RST_GATE   = 1'b0;
    localparam logic RST_STATUS = 1'b0;

    // ****************************************
    // Bus handshake states
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_ACCESS = 3'b010,
        ST_RESP   = 3'b100
    } pfc_bus_e;

    // Pause setting in force; never in half duplex
    function automatic logic pfc_pause_on(input logic manual, input logic anOn,
                                          input logic gate, input logic negotiated,
                                          input logic halfDuplex);
        logic sel;
        sel = (manual || !anOn) ? gate : negotiated;
        return sel && !halfDuplex;
    endfunction

endpackage

// *** pfc_strap_latch.sv ***
module pfc_strap_latch (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // Straps sampled at reset release
    input  wire logic backpressure_strap,
    input  wire logic full_duplex_pause_strap,
    input  wire logic manual_select_strap,
    input  wire logic duplexStrap,
    // Loader rewrite
    input  wire logic loaderWrite,
    input  wire logic loaderBackpressure,
    input  wire logic loaderPause,
    input  wire logic loaderManual,
    input  wire logic loaderDuplex,
    // Stored strap values and load pulse
    output logic      strapBackpressure,
    output logic      strapPause,
    output logic      strapManual,
    output logic      strapDuplex,
    output logic      loadPulse
);
    typedef struct packed {
        logic armed;
        logic bp;
        logic pause;
        logic man;
        logic dup;
        logic pulse;
    } pfc_strap_s;

    pfc_strap_s q, d;

    always_comb begin
        d = q;
        d.pulse = 1'b0;
        // Capture once, first cycle after reset release
        if (!q.armed) begin
            d.armed = 1'b1;
            d.bp    = backpressure_strap;
            d.pause = full_duplex_pause_strap;
            d.man   = manual_select_strap;
            d.dup   = duplexStrap;
            d.pulse = 1'b1;
        end else if (loaderWrite) begin
            d.bp    = loaderBackpressure;
            d.pause = loaderPause;
            d.man   = loaderManual;
            d.dup   = loaderDuplex;
            d.pulse = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign strapBackpressure = q.bp;
    assign strapPause        = q.pause;
    assign strapManual       = q.man;
    assign strapDuplex       = q.dup;
    assign loadPulse         = q.pulse;
endmodule

// *** pfc_pause_resolve.sv ***
module pfc_pause_resolve (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    // Selection inputs
    input  wire logic manualSel,
    input  wire logic anEnabled,
    input  wire logic rxGate,
    input  wire logic txGate,
    input  wire logic anPauseRx,
    input  wire logic anPauseTx,
    input  wire logic halfDuplex,
    // Settings in force
    output logic      pauseRxOn,
    output logic      pauseTxOn,
    output logic      duplexHalf
);
    typedef struct packed {
        logic rx;
        logic tx;
        logic dup;
    } pfc_res_s;

    pfc_res_s q, d;

    always_comb begin
        d.rx  = pfc_pkg::pfc_pause_on(manualSel, anEnabled, rxGate, anPauseRx, halfDuplex);
        d.tx  = pfc_pkg::pfc_pause_on(manualSel, anEnabled, txGate, anPauseTx, halfDuplex);
        d.dup = halfDuplex;
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            q <= {pfc_pkg::RST_STATUS, pfc_pkg::RST_STATUS, pfc_pkg::RST_STATUS};
        end else begin
            q <= d;
        end
    end

    assign pauseRxOn  = q.rx;
    assign pauseTxOn  = q.tx;
    assign duplexHalf = q.dup;
endmodule

// *** pfc_testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic        isRead;
        logic [31:0] data;
        logic        err;
    } pfc_note_s;

    // ****************************************
    // Design hookup
    // ****************************************
    logic        refClk;
    logic        sysRst;
    logic        psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr;
    logic        bpStrap, pauseStrap, manStrap, duplexStrap;
    logic        loaderWrite, loaderBackpressure, loaderPause, loaderManual, loaderDuplex;
    logic        linkHalfDuplex, anEnabled, anPauseRx, anPauseTx;
    logic        backpressureActive, pauseRxActive, pauseTxActive;
    logic        shBp, shRx, shTx, shMan;
    pfc_note_s   notes[$];
    int          failures;
    int          samplesChecked;
    int          seed;

    pfc_port_flow_ctrl #(.ADDR_W(12)) pfc_port_flow_ctrl_inst (
        .ref_clk                 (refClk),
        .sys_rst                 (sysRst),
        .psel                    (psel),
        .penable                 (penable),
        .pwrite                  (pwrite),
        .paddr                   (paddr),
        .pwdata                  (pwdata),
        .prdata                  (prdata),
        .pready                  (pready),
        .pslverr                 (pslverr),
        .backpressure_strap      (bpStrap),
        .full_duplex_pause_strap (pauseStrap),
        .manual_select_strap     (manStrap),
        .duplexStrap             (duplexStrap),
        .loaderWrite             (loaderWrite),
        .loaderBackpressure      (loaderBackpressure),
        .loaderPause             (loaderPause),
        .loaderManual            (loaderManual),
        .loaderDuplex            (loaderDuplex),
        .linkHalfDuplex          (linkHalfDuplex),
        .anEnabled               (anEnabled),
        .anPauseRx               (anPauseRx),
        .anPauseTx               (anPauseTx),
        .backpressureActive      (backpressureActive),
        .pauseRxActive           (pauseRxActive),
        .pauseTxActive           (pauseTxActive)
    );

    initial begin
        refClk = 1'b0;
        forever #12.5 refClk = ~refClk;
    end

    // ****************************************
    // Expectation and comparison
    // ****************************************
    // Half duplex forces pause off in every select mode
    function automatic logic [31:0] exp_reg();
        logic rxOn, txOn;
        rxOn = ((shMan || !anEnabled) ? shRx : anPauseRx) && !linkHalfDuplex;
        txOn = ((shMan || !anEnabled) ? shTx : anPauseTx) && !linkHalfDuplex;
        return {25'h0, shBp, linkHalfDuplex, rxOn, txOn, shRx, shTx, shMan};
    endfunction

    task automatic mismatch(input string msg);
        failures++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask

    task automatic check_bus(input pfc_note_s nt);
        samplesChecked++;
        if (pslverr !== nt.err || (nt.isRead && prdata !== nt.data))
            mismatch($sformatf("bus got %h/%b exp %h/%b", prdata, pslverr, nt.data, nt.err));
    endtask

    task automatic check_out(input logic got, input logic exp, input string what);
        samplesChecked++;
        if (got !== exp)
            mismatch($sformatf("%s got %b exp %b", what, got, exp));
    endtask

    always @(posedge refClk) begin
        if (pready === 1'b1) begin
            if (notes.size() == 0)
                mismatch("unexpected pready");
            else
                check_bus(notes.pop_front());
        end
    end

    // ****************************************
    // Drivers
    // ****************************************
    // Called right after a rising edge; hold keeps psel for a back-to-back setup
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] expD, input logic expErr, input logic hold);
        int n;
        notes.push_back(pfc_note_s'{~wr, expD, expErr});
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge refClk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge refClk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            mismatch("no pready");
        penable <= 1'b0;
        if (!hold)
            psel <= 1'b0;
    endtask

    task automatic check_state();
        logic [31:0] e;
        e = exp_reg();
        apb(1'b0, pfc_pkg::REG_OFFSET, 32'h0, e, 1'b0, 1'b0);
        check_out(pauseRxActive, e[4], "rx active");
        check_out(pauseTxActive, e[3], "tx active");
        check_out(backpressureActive, e[6] && linkHalfDuplex, "bp active");
    endtask

    // Duplex strap and live duplex kept equal so either source gives one answer
    task automatic do_reset();
        logic [5:0] s;
        s = 6'($random(seed));
        sysRst         <= 1'b1;
        bpStrap        <= s[0];
        pauseStrap     <= s[1];
        manStrap       <= s[2];
        duplexStrap    <= s[3];
        linkHalfDuplex <= s[3];
        anEnabled      <= s[4];
        anPauseRx      <= s[5];
        anPauseTx      <= ~s[5];
        {shBp, shRx, shTx, shMan} = {s[0], s[1], s[1], s[2]};
        repeat (8) @(posedge refClk);
        sysRst <= 1'b0;
        repeat (4) @(posedge refClk);
    endtask

    task automatic report_and_stop();
        $display("checks %0d failures %0d", samplesChecked, failures);
        if (failures == 0 && samplesChecked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (20000) @(posedge refClk);
        mismatch("watchdog expired");
        report_and_stop();
    end

    initial begin
        logic [31:0] d;
        logic [2:0]  s;
        int          m;
        seed = 81522;
        failures = 0;
        samplesChecked = 0;
        {sysRst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 3'b000, 12'h0, 32'h0};
        {bpStrap, pauseStrap, manStrap, duplexStrap} = 4'h0;
        {loaderWrite, loaderBackpressure, loaderPause, loaderManual, loaderDuplex} = 5'h0;
        {linkHalfDuplex, anEnabled, anPauseRx, anPauseTx} = 4'h0;
        @(posedge refClk);
        do_reset();
        check_state();
        $display("test reset defaults done");
        for (m = 0; m < 16; m++) begin
            s = 3'($random(seed));
            anEnabled      <= m[1];
            linkHalfDuplex <= m[2];
            anPauseRx      <= s[0];
            anPauseTx      <= s[1];
            repeat (3) @(posedge refClk);
            d = $random(seed);
            d[0] = m[0];
            apb(1'b1, pfc_pkg::REG_OFFSET, d, 32'h0, 1'b0, 1'b0);
            {shBp, shRx, shTx, shMan} = {d[6], d[2], d[1], d[0]};
            repeat (3) @(posedge refClk);
            check_state();
        end
        $display("test select modes done");
        // Unmapped places answer with an error and leave the register alone
        d = $random(seed);
        apb(1'b1, pfc_pkg::REG_OFFSET + 12'h004, d, 32'h0, 1'b1, 1'b1);
        apb(1'b0, pfc_pkg::REG_OFFSET - 12'h004, 32'h0, 32'h0, 1'b1, 1'b1);
        apb(1'b0, pfc_pkg::REG_OFFSET, 32'h0, exp_reg(), 1'b0, 1'b0);
        $display("test unmapped access done");
        do_reset();
        check_state();
        $display("test second reset done");
        for (m = 0; m < 4; m++) begin
            s = 3'($random(seed));
            loaderWrite        <= 1'b1;
            loaderBackpressure <= s[0];
            loaderPause        <= s[1];
            loaderManual       <= s[2];
            loaderDuplex       <= linkHalfDuplex;
            @(posedge refClk);
            loaderWrite <= 1'b0;
            {shBp, shRx, shTx, shMan} = {s[0], s[1], s[1], s[2]};
            repeat (4) @(posedge refClk);
            check_state();
        end
        $display("test loader rewrite done");
        report_and_stop();
    end

endmodule
